// >>> logic/sbc_boot.sv
// Serial boot record parser, password check, checksum and reply FIFO
`timescale 1ns/1ps
`include "sbc_params.svh"

////////////////////////////////////////////////////////////////////////////
// Reply FIFO; reader can stall, so the writer sees honest back-pressure
module sbc_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    input  wire logic         core_clk,  // System clock
    input  wire logic         nrst,      // Sync reset, active low
    input  wire logic         in_valid,  // Write request
    output logic              in_ready,  // Room left
    input  wire logic [W-1:0] in_data,   // Write data
    output logic              out_valid, // Data available
    input  wire logic         out_ready, // Reader takes
    output logic      [W-1:0] out_data   // Head word
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem_q [D];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0]   cnt_q;
    logic          wr_en;
    logic          rd_en;

    // Handshakes
    assign in_ready  = (cnt_q != D[AW:0]);
    assign out_valid = (cnt_q != '0);
    assign wr_en     = in_valid && in_ready;
    assign rd_en     = out_valid && out_ready;
    assign out_data  = mem_q[rp_q];

    // Storage
    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem_q[wp_q] <= in_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (wr_en) begin
                wp_q <= (wp_q == AW'(D - 1)) ? '0 : wp_q + 1'b1;
            end
            if (rd_en) begin
                rp_q <= (rp_q == AW'(D - 1)) ? '0 : rp_q + 1'b1;
            end
            cnt_q <= cnt_q + {{AW{1'b0}}, wr_en} - {{AW{1'b0}}, rd_en};
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////
module sbc_boot
    import sbc_pkg::*;
(
    input  wire logic        core_clk,      // System clock, 50 MHz
    input  wire logic        nrst,          // Sync reset, active low
    input  wire logic        start_i,       // Begin session, pulse
    input  wire logic [1:0]  mode_i,        // Session mode at start
    input  wire logic        baud_err_i,    // Bad baud-rate change, pulse
    input  wire logic        cmd_err_i,     // Unknown command, pulse
    input  wire logic        rx_valid_i,    // Received byte strobe
    input  wire logic [7:0]  rx_data_i,     // Received byte
    input  wire logic        rx_frame_err_i, // Framing error, pulse
    input  wire logic        rx_overrun_i,  // Overrun, pulse
    output logic             tx_valid,      // Reply byte ready
    input  wire logic        tx_ready,      // Transmitter takes byte
    output logic      [7:0]  tx_data,       // Reply byte
    output logic             mem_rd,        // Flash read request
    output logic      [15:0] mem_addr,      // Flash read address
    input  wire logic [7:0]  mem_rdata,     // Flash data, next cycle
    output logic             wr_valid,      // Data byte write pulse
    output logic             wr_ram,        // Write targets RAM
    output logic      [15:0] wr_addr,       // Write address
    output logic      [7:0]  wr_data,       // Write data
    output logic      [15:0] checksum_word, // Last checksum
    output logic             halted,        // Session stopped
    output logic             pw_error,      // Password error seen
    output logic             fmt_error,     // Record or receive error
    output logic             done           // Both checksum bytes queued in FIFO
);
    sbc_state_e  st_q;
    sbc_mode_e   mode_q;
    logic        blank_q, ext_big_q, pw_err_q, fmt_err_q, wr_valid_q, wr_ram_q;
    logic [7:0]  idx_q, cnt_q, len_q, rtype_q, rsum_q, rxb_q, p1_q, p2_q;
    logic [7:0]  err_code_q, wr_data_q;
    logic [1:0]  err_cnt_q;
    logic        tx_hi_q;
    logic [15:0] loc_q, cmp_q, addr_q, raddr_q, ext_q, sum_q, wr_addr_q;
    logic        rx_err, rx_ok, hex_ph, live, loud_ev, silent_ev;
    logic [7:0]  ev_code;
    logic        push_valid, push_ready;
    logic [7:0]  push_data;

    // Modulo 65536 byte add
    function automatic logic [15:0] add16(input logic [15:0] a, input logic [7:0] b);
        add16 = a + {8'h00, b};
    endfunction

    // Address inside the password area
    function automatic logic in_pw(input logic [15:0] a);
        in_pw = (a >= `SBC_PW_LO) && (a <= `SBC_PW_HI);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Event classification; loud errors win over a byte in the same cycle
    assign rx_err = rx_frame_err_i | rx_overrun_i;
    assign hex_ph = (st_q >= ST_HX_MK) && (st_q <= ST_HX_CK);
    assign live   = (st_q != ST_TX_ERR) && (st_q != ST_HALT) && (st_q != ST_DONE);
    assign rx_ok  = rx_valid_i && !rx_err && !baud_err_i && !cmd_err_i;
    assign loud_ev = live && (baud_err_i || cmd_err_i
                     || (rx_err && !hex_ph && st_q != ST_IDLE));
    assign silent_ev = hex_ph && rx_err && !baud_err_i && !cmd_err_i;
    always_comb begin
        if (baud_err_i) begin
            ev_code = `SBC_ERR_BAUD;
        end else if (cmd_err_i) begin
            ev_code = `SBC_ERR_CMD;
        end else if (rx_frame_err_i) begin
            ev_code = `SBC_ERR_FRAME;
        end else begin
            ev_code = `SBC_ERR_OVRUN;
        end
    end

    // Reply pushes; FIFO full stalls the sending states
    assign push_valid = (st_q == ST_TX_ERR) || (st_q == ST_TX_SUM);
    assign push_data  = (st_q == ST_TX_ERR) ? err_code_q
                      : (tx_hi_q ? sum_q[15:8] : sum_q[7:0]);

    sbc_fifo #(.W(`SBC_FIFO_W), .D(`SBC_FIFO_D)) u_fifo (
        .core_clk  (core_clk),
        .nrst      (nrst),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_data),
        .out_valid (tx_valid),
        .out_ready (tx_ready),
        .out_data  (tx_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Session sequencer
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            st_q <= ST_IDLE;     mode_q <= SBC_MODE_FLASH; blank_q <= 1'b1;
            ext_big_q <= 1'b0;   pw_err_q <= 1'b0;         fmt_err_q <= 1'b0;
            idx_q <= 8'h00;      cnt_q <= 8'h00;           len_q <= 8'h00;
            rtype_q <= 8'h00;    rsum_q <= 8'h00;          rxb_q <= 8'h00;
            p1_q <= 8'h00;       p2_q <= 8'h00;            err_code_q <= 8'h00;
            err_cnt_q <= 2'h0;   tx_hi_q <= 1'b1;          loc_q <= 16'h0000;
            cmp_q <= 16'h0000;   addr_q <= 16'h0000;       raddr_q <= 16'h0000;
            ext_q <= 16'h0000;
        end else if (loud_ev) begin
            st_q       <= ST_TX_ERR;
            err_code_q <= ev_code;
            err_cnt_q  <= 2'h0;
        end else if (silent_ev) begin
            st_q      <= ST_HALT;
            fmt_err_q <= 1'b1;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (start_i) begin
                        mode_q    <= sbc_mode_e'(mode_i);
                        blank_q   <= 1'b1;
                        ext_big_q <= 1'b0;
                        addr_q    <= `SBC_BLANK_LO;
                        idx_q     <= 8'h00;
                        tx_hi_q   <= 1'b1;
                        st_q      <= ST_BLK_RD;
                    end
                end
                ST_BLK_RD: st_q <= ST_BLK_CHK;
                ST_BLK_CHK: begin
                    // Any byte other than 00H or FFH marks a programmed part
                    if (mem_rdata != 8'h00 && mem_rdata != 8'hFF) begin
                        blank_q <= 1'b0;
                    end
                    addr_q <= addr_q + 16'h0001;
                    st_q   <= (addr_q == `SBC_FLASH_HI) ? ST_LOC : ST_BLK_RD;
                end
                ST_LOC: begin
                    // Both addresses come even for a blank part
                    if (rx_ok) begin
                        idx_q <= idx_q + 8'h01;
                        case (idx_q[1:0])
                            2'h0: loc_q[15:8] <= rx_data_i;
                            2'h1: loc_q[7:0]  <= rx_data_i;
                            2'h2: cmp_q[15:8] <= rx_data_i;
                            default: begin
                                cmp_q[7:0] <= rx_data_i;
                                idx_q      <= 8'h00;
                                if (!in_pw(loc_q) || !in_pw({cmp_q[15:8], rx_data_i})) begin
                                    pw_err_q <= 1'b1;
                                    st_q     <= ST_HALT;
                                end else if (blank_q) begin
                                    st_q <= ST_HX_MK;
                                end else begin
                                    addr_q <= loc_q;
                                    st_q   <= ST_CNT_RD;
                                end
                            end
                        endcase
                    end
                end
                ST_CNT_RD: st_q <= ST_CNT_CHK;
                ST_CNT_CHK: begin
                    cnt_q <= mem_rdata;
                    if (mem_rdata < `SBC_PW_MIN
                        || ({1'b0, cmp_q} + {9'h000, mem_rdata}) > `SBC_VEC_BASE) begin
                        pw_err_q <= 1'b1;
                        st_q     <= ST_HALT;
                    end else begin
                        st_q <= ST_PW_RX;
                    end
                end
                ST_PW_RX: begin
                    if (rx_ok) begin
                        rxb_q  <= rx_data_i;
                        addr_q <= cmp_q + {8'h00, idx_q};
                        st_q   <= ST_PW_RD;
                    end
                end
                ST_PW_RD: st_q <= ST_PW_CHK;
                ST_PW_CHK: begin
                    p1_q  <= mem_rdata;
                    p2_q  <= p1_q;
                    idx_q <= idx_q + 8'h01;
                    if (mem_rdata != rxb_q) begin
                        pw_err_q <= 1'b1;
                        st_q     <= ST_HALT;
                    end else if (idx_q >= 8'h02 && mem_rdata == p1_q && p1_q == p2_q) begin
                        pw_err_q <= 1'b1;
                        st_q     <= ST_HALT;
                    end else begin
                        st_q <= (idx_q + 8'h01 == cnt_q) ? ST_HX_MK : ST_PW_RX;
                    end
                end
                ST_HX_MK: begin
                    // Stray bytes between records are dropped
                    if (rx_ok && rx_data_i == `SBC_MARK) begin
                        rsum_q <= 8'h00;
                        st_q   <= ST_HX_LEN;
                    end
                end
                ST_HX_LEN: begin
                    if (rx_ok) begin
                        len_q  <= rx_data_i;
                        rsum_q <= rx_data_i;
                        st_q   <= ST_HX_AH;
                    end
                end
                ST_HX_AH: begin
                    if (rx_ok) begin
                        raddr_q[15:8] <= rx_data_i;
                        rsum_q        <= rsum_q + rx_data_i;
                        st_q          <= ST_HX_AL;
                    end
                end
                ST_HX_AL: begin
                    if (rx_ok) begin
                        raddr_q[7:0] <= rx_data_i;
                        rsum_q       <= rsum_q + rx_data_i;
                        st_q         <= ST_HX_TY;
                    end
                end
                ST_HX_TY: begin
                    if (rx_ok) begin
                        rtype_q <= rx_data_i;
                        rsum_q  <= rsum_q + rx_data_i;
                        idx_q   <= 8'h00;
                        if (rx_data_i > `SBC_REC_EXT
                            || (rx_data_i == `SBC_REC_EXT && len_q != `SBC_EXT_LEN)
                            || (rx_data_i == `SBC_REC_END && len_q != `SBC_END_LEN)
                            || (rx_data_i == `SBC_REC_DATA && ext_big_q)) begin
                            fmt_err_q <= 1'b1;
                            st_q      <= ST_HALT;
                        end else begin
                            st_q <= (len_q == 8'h00) ? ST_HX_CK : ST_HX_DAT;
                        end
                    end
                end
                ST_HX_DAT: begin
                    if (rx_ok) begin
                        rsum_q  <= rsum_q + rx_data_i;
                        raddr_q <= raddr_q + 16'h0001;
                        ext_q   <= {ext_q[7:0], rx_data_i};
                        idx_q   <= idx_q + 8'h01;
                        if (idx_q + 8'h01 == len_q) begin
                            st_q <= ST_HX_CK;
                        end
                    end
                end
                ST_HX_CK: begin
                    if (rx_ok) begin
                        if (rsum_q + rx_data_i != 8'h00) begin
                            fmt_err_q <= 1'b1;
                            st_q      <= ST_HALT;
                        end else if (rtype_q == `SBC_REC_END) begin
                            addr_q <= `SBC_FLASH_LO;
                            st_q   <= (mode_q == SBC_MODE_RAM) ? ST_TX_SUM : ST_SUM_RD;
                        end else begin
                            if (rtype_q == `SBC_REC_EXT) begin
                                ext_big_q <= (ext_q > `SBC_EXT_LIMIT);
                            end
                            st_q <= ST_HX_MK;
                        end
                    end
                end
                ST_SUM_RD: st_q <= ST_SUM_ADD;
                ST_SUM_ADD: begin
                    addr_q <= addr_q + 16'h0001;
                    st_q   <= (addr_q == `SBC_FLASH_HI) ? ST_TX_SUM : ST_SUM_RD;
                end
                ST_TX_SUM: begin
                    if (push_ready) begin
                        tx_hi_q <= 1'b0;
                        if (!tx_hi_q) begin
                            st_q <= ST_DONE;
                        end
                    end
                end
                ST_TX_ERR: begin
                    if (push_ready) begin
                        err_cnt_q <= err_cnt_q + 2'h1;
                        if (err_cnt_q == `SBC_ERR_REPEAT - 2'h1) begin
                            st_q <= ST_HALT;
                        end
                    end
                end
                ST_DONE: begin
                    if (start_i) begin
                        st_q <= ST_IDLE;
                    end
                end
                ST_HALT: st_q <= ST_HALT;
                default: st_q <= ST_HALT;
            endcase
        end
    end

    // Checksum word; RAM mode sums data record bytes, other modes sum the flash sweep after the end record
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            sum_q <= 16'h0000;
        end else if (st_q == ST_IDLE && start_i) begin
            sum_q <= 16'h0000;
        end else if (st_q == ST_SUM_ADD) begin
            sum_q <= add16(sum_q, mem_rdata);
        end else if (st_q == ST_HX_DAT && rx_ok && !loud_ev && mode_q == SBC_MODE_RAM
                     && rtype_q == `SBC_REC_DATA) begin
            sum_q <= add16(sum_q, rx_data_i);
        end
    end

    // Data byte write port, one pulse per data record byte
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            wr_valid_q <= 1'b0;
            wr_ram_q   <= 1'b0;
            wr_addr_q  <= 16'h0000;
            wr_data_q  <= 8'h00;
        end else begin
            wr_valid_q <= (st_q == ST_HX_DAT) && rx_ok && rtype_q == `SBC_REC_DATA;
            wr_ram_q   <= (mode_q == SBC_MODE_RAM);
            wr_addr_q  <= raddr_q;
            wr_data_q  <= rx_data_i;
        end
    end

    // Outputs
    assign mem_rd = (st_q == ST_BLK_RD) || (st_q == ST_CNT_RD)
                 || (st_q == ST_PW_RD) || (st_q == ST_SUM_RD);
    assign mem_addr      = addr_q;
    assign wr_valid      = wr_valid_q;
    assign wr_ram        = wr_ram_q;
    assign wr_addr       = wr_addr_q;
    assign wr_data       = wr_data_q;
    assign checksum_word = sum_q;
    assign halted        = (st_q == ST_HALT);
    assign pw_error      = pw_err_q;
    assign fmt_error     = fmt_err_q;
    assign done          = (st_q == ST_DONE);

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    AST_BAUD_CODE: assert property (live && baud_err_i |=>
        st_q == ST_TX_ERR && err_code_q == 8'h62) else $error("baud code");
    AST_CMD_CODE: assert property (live && cmd_err_i && !baud_err_i |=>
        err_code_q == 8'h63) else $error("command code");
    AST_FRAME_CODE: assert property (loud_ev && rx_frame_err_i && !baud_err_i
        && !cmd_err_i |=> err_code_q == 8'hA1) else $error("frame code");
    AST_OVRUN_CODE: assert property (loud_ev && rx_overrun_i && !rx_frame_err_i
        && !baud_err_i && !cmd_err_i |=> err_code_q == 8'hA3) else $error("overrun code");
    AST_TRIPLE: assert property (st_q == ST_TX_ERR && push_ready && err_cnt_q == 2'h2
        |=> st_q == ST_HALT) else $error("error code not tripled");
    AST_SUM_HI: assert property ($rose(st_q == ST_TX_SUM) |-> push_data == sum_q[15:8])
        else $error("checksum high byte not first");
    AST_SUM_WRAP: assert property (st_q == ST_SUM_ADD |=>
        sum_q == 16'($past(sum_q) + {8'h00, $past(mem_rdata)})) else $error("sum add");
    AST_MARK_WAIT: assert property (st_q == ST_HX_MK && rx_ok && !loud_ev
        && rx_data_i != 8'h3A |=> st_q == ST_HX_MK) else $error("stray byte taken");
    AST_BAD_TYPE: assert property (st_q == ST_HX_TY && rx_ok && !loud_ev
        && rx_data_i > 8'h02 |=> halted && fmt_error) else $error("bad record type");
    AST_SILENT: assert property (pw_err_q |-> halted && !push_valid)
        else $error("reply after password error");
    AST_BLANK: assert property (st_q == ST_BLK_CHK && !loud_ev && mem_rdata != 8'h00
        && mem_rdata != 8'hFF |=> !blank_q) else $error("blank flag kept");

    COV_TRIPLE: cover property (st_q == ST_TX_ERR ##1 st_q == ST_TX_ERR [*2] ##1 halted);
    COV_DONE:   cover property (st_q == ST_TX_SUM ##[1:40] done);
    COV_PW:     cover property (st_q == ST_PW_CHK ##1 st_q == ST_PW_RX);
endmodule

// >>> logic/sbc_params.svh
// Constants of the serial boot checksum and password checker
`ifndef SBC_PARAMS_SVH
`define SBC_PARAMS_SVH
`define SBC_ERR_BAUD   8'h62
`define SBC_ERR_CMD    8'h63
`define SBC_ERR_FRAME  8'hA1
`define SBC_ERR_OVRUN  8'hA3
`define SBC_ERR_REPEAT 2'h3
`define SBC_MARK       8'h3A
`define SBC_REC_DATA   8'h00
`define SBC_REC_END    8'h01
`define SBC_REC_EXT    8'h02
`define SBC_EXT_LEN    8'h02
`define SBC_END_LEN    8'h00
`define SBC_EXT_LIMIT  16'h1000
`define SBC_PW_LO      16'hE000
`define SBC_PW_HI      16'hFF9F
`define SBC_VEC_BASE   17'h0FFA0
`define SBC_BLANK_LO   16'hFFE0
`define SBC_FLASH_LO   16'hE000
`define SBC_FLASH_HI   16'hFFFF
`define SBC_PW_MIN     8'h08
`define SBC_FIFO_W     8
`define SBC_FIFO_D     32
`endif

// >>> logic/sbc_pkg.sv
// Types of the serial boot checksum and password checker
package sbc_pkg;
    typedef enum logic [1:0] {
        SBC_MODE_FLASH = 2'b00,
        SBC_MODE_RAM   = 2'b01,
        SBC_MODE_SUM   = 2'b10
    } sbc_mode_e;
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00000, ST_BLK_RD = 5'b00001, ST_BLK_CHK = 5'b00010,
        ST_LOC   = 5'b00011, ST_CNT_RD = 5'b00100, ST_CNT_CHK = 5'b00101,
        ST_PW_RX = 5'b00110, ST_PW_RD  = 5'b00111, ST_PW_CHK  = 5'b01000,
        ST_HX_MK = 5'b01001, ST_HX_LEN = 5'b01010, ST_HX_AH   = 5'b01011,
        ST_HX_AL = 5'b01100, ST_HX_TY  = 5'b01101, ST_HX_DAT  = 5'b01110,
        ST_HX_CK = 5'b01111, ST_SUM_RD = 5'b10000, ST_SUM_ADD = 5'b10001,
        ST_TX_SUM = 5'b10010, ST_TX_ERR = 5'b10011, ST_HALT   = 5'b10100,
        ST_DONE  = 5'b10101
    } sbc_state_e;
endpackage

// >>> sim/sbc_flash_model.sv
// Flash array model answering read requests one cycle later
`timescale 1ns/1ps
module sbc_flash_model (
    input  wire logic        core_clk,  // System clock
    input  wire logic        mem_rd,    // Read request
    input  wire logic [15:0] mem_addr,  // Read address
    input  wire logic        fill_ff,   // Erased array when high
    output logic      [7:0]  mem_rdata  // Read data
);
    ////////////////////////////////////////////////////////////////////////
    // Idle cycles invert the previous output, so the last read value reappears every second idle cycle
    initial mem_rdata = 8'h00;
    always @(posedge core_clk) begin
        if (mem_rd) begin
            mem_rdata <= fill_ff ? 8'hFF : mem_addr[7:0];
        end else begin
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule

// >>> sim/testbench.sv
// Self-checking bench for the serial boot checker
`timescale 1ns/1ps
module testbench;
    logic core_clk = 1'b0, nrst = 1'b0, start_i = 1'b0, baud_err_i = 1'b0, cmd_err_i = 1'b0;
    logic rx_valid_i = 1'b0, rx_frame_err_i = 1'b0, rx_overrun_i = 1'b0, tx_ready = 1'b0;
    logic [1:0] mode_i = 2'h0;
    logic [7:0] rx_data_i = 8'h00, mem_rdata, tx_data, wr_data;
    logic tx_valid, mem_rd, wr_valid, wr_ram, halted, pw_error, fmt_error, done;
    logic [15:0] mem_addr, wr_addr, checksum_word;
    int miscompares = 0, n_compared = 0, cycles = 0;
    logic fill_ff = 1'b1;
    sbc_boot DUT (.core_clk, .nrst, .start_i, .mode_i, .baud_err_i, .cmd_err_i, .rx_valid_i,
        .rx_data_i, .rx_frame_err_i, .rx_overrun_i, .tx_valid, .tx_ready, .tx_data, .mem_rd,
        .mem_addr, .mem_rdata, .wr_valid, .wr_ram, .wr_addr, .wr_data, .checksum_word,
        .halted, .pw_error, .fmt_error, .done);
    sbc_flash_model flash (.core_clk, .mem_rd, .mem_addr, .fill_ff, .mem_rdata);
    // Data write port capture; reset clears only the count
    logic [15:0] last_wr_addr = 16'h0000;
    logic [7:0]  last_wr_data = 8'h00;
    logic        last_wr_ram  = 1'b0;
    int          n_wr         = 0;
    always @(posedge core_clk) begin
        if (!nrst) begin
            n_wr <= 0;
        end else if (wr_valid === 1'b1) begin
            n_wr         <= n_wr + 1;
            last_wr_addr <= wr_addr;
            last_wr_data <= wr_data;
            last_wr_ram  <= wr_ram;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Clock and hang guard; the ceiling covers all scenarios with margin
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            miscompares++;
            close_out();
        end
    end
    task automatic close_out();
        $display("compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input bit ok);
        n_compared++;
        if (!ok) begin
            $display("unexpected at %0t: value mismatch", $time);
            miscompares++;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Reset, session start, byte feed and reply pop
    task automatic begin_s(input logic [1:0] m);
        @(posedge core_clk) nrst <= 1'b0;
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk) mode_i <= m;
        start_i <= 1'b1;
        @(posedge core_clk) start_i <= 1'b0;
    endtask
    // Four idle cycles between bytes respect the acceptance spacing
    task automatic feed(input logic [7:0] q[$]);
        foreach (q[i]) begin
            @(posedge core_clk) rx_valid_i <= 1'b1;
            rx_data_i <= q[i];
            @(posedge core_clk) rx_valid_i <= 1'b0;
            repeat (3) @(posedge core_clk);
        end
    endtask
    task automatic get(input logic [7:0] e);
        for (int i = 0; i < 80 && tx_valid !== 1'b1; i++) begin
            @(posedge core_clk);
            #1;
        end
        chk(tx_valid === 1'b1 && tx_data === e);
        @(posedge core_clk) tx_ready <= 1'b1;
        @(posedge core_clk) tx_ready <= 1'b0;
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_loud(input int k, input logic [7:0] e);
        begin_s(2'h0);
        repeat (4) @(posedge core_clk);
        case (k)
            0: baud_err_i <= 1'b1;
            1: cmd_err_i <= 1'b1;
            2: rx_frame_err_i <= 1'b1;
            default: rx_overrun_i <= 1'b1;
        endcase
        @(posedge core_clk) {baud_err_i, cmd_err_i, rx_frame_err_i, rx_overrun_i} <= 4'h0;
        repeat (3) get(e);
        repeat (4) @(posedge core_clk);
        #1 chk(halted === 1'b1 && tx_valid === 1'b0);
    endtask
    // Blank array: records follow the two addresses, junk before mark dropped
    task automatic t_ram();
        begin_s(2'h1);
        repeat (80) @(posedge core_clk);
        feed('{8'hE0, 8'h00, 8'hE0, 8'h10, 8'h55, 8'h3A, 8'h02, 8'hE0, 8'h00, 8'h00});
        feed('{8'hA1, 8'hB2, 8'hCB, 8'h77, 8'h3A, 8'h00, 8'h00, 8'h00, 8'h01, 8'hFF});
        get(8'h01);
        get(8'h53);
        repeat (3) @(posedge core_clk);
        #1 chk(done === 1'b1 && checksum_word === 16'h0153);
        chk(n_wr == 2 && last_wr_ram === 1'b1);
        chk(last_wr_addr === 16'hE001 && last_wr_data === 8'hB2);
    endtask
    // Programmed array: short count or a wrong byte halts with no reply
    task automatic t_pw(input logic [7:0] lo);
        @(posedge core_clk) fill_ff <= 1'b0;
        begin_s(2'h0);
        repeat (80) @(posedge core_clk);
        feed('{8'hE0, lo, 8'hE0, 8'h10, 8'h10, 8'h11, 8'h12, 8'h55});
        repeat (20) @(posedge core_clk);
        #1 chk(pw_error === 1'b1 && halted === 1'b1 && tx_valid === 1'b0);
        chk(fmt_error === 1'b0 && mem_rd === 1'b0);
    endtask
    // Erased array in sum mode: 8192 bytes of FFH wrap the word to E000H
    task automatic t_flash();
        @(posedge core_clk) fill_ff <= 1'b1;
        begin_s(2'h2);
        repeat (80) @(posedge core_clk);
        feed('{8'hE0, 8'h00, 8'hE0, 8'h10, 8'h3A, 8'h00, 8'h00, 8'h00, 8'h01, 8'hFF});
        repeat (16400) @(posedge core_clk);
        get(8'hE0);
        get(8'h00);
        repeat (3) @(posedge core_clk);
        #1 chk(done === 1'b1 && checksum_word === 16'hE000);
    endtask
    task automatic t_bad_type();
        begin_s(2'h1);
        repeat (80) @(posedge core_clk);
        feed('{8'hE0, 8'h00, 8'hE0, 8'h10, 8'h3A, 8'h00, 8'h00, 8'h00, 8'h03, 8'hFD});
        repeat (20) @(posedge core_clk);
        #1 chk(fmt_error === 1'b1 && halted === 1'b1 && tx_valid === 1'b0);
    endtask
    initial begin
        t_loud(0, 8'h62);
        t_loud(1, 8'h63);
        t_loud(2, 8'hA1);
        t_loud(3, 8'hA3);
        t_ram();
        t_bad_type();
        t_pw(8'h08);
        t_pw(8'h04);
        t_flash();
        close_out();
    end
endmodule
